/* inc/isc_pkg.sv */
/*
  Package for the in-line security control block: register offsets,
  field positions, reset values and mode encodings.
  Assumes a 16-bit configuration register port on the system clock.
*/
package isc_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [5:0]  SECURITY_CONTROL_ADDR = 6'h19;
  localparam logic [5:0]  CLEAR_COUNT_ADDR      = 6'h1A;

  // ----------------------------------------------------------------
  // security_control field positions
  // ----------------------------------------------------------------
  localparam int GUARD_BIT    = 9;
  localparam int HEAD_BIT     = 8;
  localparam int SAKEY_BIT    = 7;
  localparam int TXKEY_BIT    = 6;
  localparam int RXKEY_BIT    = 5;
  localparam int TAG_LSB      = 2;
  localparam int MODE_LSB     = 0;

  // ----------------------------------------------------------------
  // clear_count field positions
  // ----------------------------------------------------------------
  localparam int TXL_LSB      = 8;
  localparam int RXL_LSB      = 0;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic        GUARD_RST   = 1'h1;
  localparam logic        HEAD_RST    = 1'h1;
  localparam logic        SAKEY_RST   = 1'h1;
  localparam logic        TXKEY_RST   = 1'h1;
  localparam logic        RXKEY_RST   = 1'h0;
  localparam logic [2:0]  TAG_RST     = 3'h1;
  localparam logic [1:0]  MODE_RST    = 2'h0;
  localparam logic [6:0]  CLEAR_RST   = 7'h00;
  localparam logic [4:0]  TAG_BYTES_RST = 5'h04;

  // ----------------------------------------------------------------
  // tag length code and packet arithmetic
  // ----------------------------------------------------------------
  localparam logic [2:0]  TAG_RESERVED = 3'h0;
  localparam logic [7:0]  LEN_OVERHEAD = 8'h02;

  typedef enum logic [1:0] {
    ISC_OFF = 2'h0,
    ISC_MAC = 2'h1,
    ISC_CTR = 2'h2,
    ISC_CCM = 2'h3
  } isc_mode_e;

endpackage : isc_pkg

/* src/isc_control.sv */
/*
  In-line security control: configuration registers, per-operation
  latching of settings, key choice and CBC-MAC head byte.
  Assumes a host register port on ref_clk and an AES datapath that
  raises op_start for one cycle at the start of each operation.
*/
// Summary of operation
// - bit 9 guards receive buffer, resets one
// - head select zero: first data byte first
// - head select one: authenticated length first
// - head select ignored inside CCM
// - three key selectors, resets one one zero
// - tag code (M-2)/2, zero reserved, reset one
// - mode field, reset disables security
// - seven-bit tx and rx clear counts
`timescale 1ns/10ps
module isc_control (
  input  wire logic        ref_clk,           // system clock, 40 MHz
  input  wire logic        rstn,              // async reset, active low
  input  wire logic [5:0]  reg_addr,          // register address
  input  wire logic        reg_wr,            // write strobe
  input  wire logic [15:0] reg_wdata,         // write data
  input  wire logic        reg_rd,            // read strobe
  output logic      [15:0] reg_rdata,         // read data
  input  wire logic        op_start,          // operation start pulse
  input  wire logic [1:0]  op_kind,           // 0 standalone, 1 tx, 2 rx
  input  wire logic [7:0]  pkt_len,           // packet length field
  input  wire logic [7:0]  first_data,        // first payload byte
  output logic             rx_buffer_guard_en,// receive buffer guard
  output logic [1:0]       active_mode,       // latched mode
  output logic [2:0]       active_tag_code,   // latched tag code
  output logic [4:0]       active_tag_bytes,  // tag length in bytes
  output logic             active_key,        // 0 key 0, 1 key 1
  output logic [6:0]       active_clear,      // clear count for op
  output logic [7:0]       mac_head_byte,     // first CBC-MAC byte
  output logic             mac_len_first,     // length byte prepended
  output logic             tag_code_err       // reserved tag code set
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic       mac_head_select;
  logic       standalone_key_choice;
  logic       transmit_key_choice;
  logic       receive_key_choice;
  logic [2:0] tag_length_code;
  logic [1:0] inline_protect_mode;
  logic [6:0] tx_clear_count;
  logic [6:0] rx_clear_count;
  logic       lat_head;
  logic       lat_rx;
  logic [6:0] lat_txl;
  logic [6:0] lat_rxl;

  wire logic        wr_ctrl;
  wire logic        wr_clear;
  wire logic        is_standalone;
  wire logic        is_rx;
  wire logic [15:0] ctrl_view;
  wire logic [15:0] clear_view;
  wire logic [15:0] next_rdata;
  wire logic        next_key;
  wire logic [6:0]  next_clear;
  wire logic [7:0]  head_byte;
  wire logic        len_first;

  assign wr_ctrl  = reg_wr & (reg_addr == isc_pkg::SECURITY_CONTROL_ADDR);
  assign wr_clear = reg_wr & (reg_addr == isc_pkg::CLEAR_COUNT_ADDR);

  // upper bits are not stored, so reserved positions read zero
  assign ctrl_view  = {6'h00, rx_buffer_guard_en, mac_head_select,
                       standalone_key_choice, transmit_key_choice,
                       receive_key_choice, tag_length_code,
                       inline_protect_mode};
  assign clear_view = {1'b0, tx_clear_count, 1'b0, rx_clear_count};
  assign next_rdata = (reg_addr == isc_pkg::SECURITY_CONTROL_ADDR) ? ctrl_view
                    : (reg_addr == isc_pkg::CLEAR_COUNT_ADDR) ? clear_view
                    : 16'h0000;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rx_buffer_guard_en    <= isc_pkg::GUARD_RST;
      mac_head_select       <= isc_pkg::HEAD_RST;
      standalone_key_choice <= isc_pkg::SAKEY_RST;
      transmit_key_choice   <= isc_pkg::TXKEY_RST;
      receive_key_choice    <= isc_pkg::RXKEY_RST;
      tag_length_code       <= isc_pkg::TAG_RST;
      inline_protect_mode   <= isc_pkg::MODE_RST;
    end
    else if (wr_ctrl)
    begin
      rx_buffer_guard_en    <= reg_wdata[isc_pkg::GUARD_BIT];
      mac_head_select       <= reg_wdata[isc_pkg::HEAD_BIT];
      standalone_key_choice <= reg_wdata[isc_pkg::SAKEY_BIT];
      transmit_key_choice   <= reg_wdata[isc_pkg::TXKEY_BIT];
      receive_key_choice    <= reg_wdata[isc_pkg::RXKEY_BIT];
      tag_length_code       <= reg_wdata[isc_pkg::TAG_LSB +: 3];
      inline_protect_mode   <= reg_wdata[isc_pkg::MODE_LSB +: 2];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      tx_clear_count <= isc_pkg::CLEAR_RST;
      rx_clear_count <= isc_pkg::CLEAR_RST;
    end
    else if (wr_clear)
    begin
      tx_clear_count <= reg_wdata[isc_pkg::TXL_LSB +: 7];
      rx_clear_count <= reg_wdata[isc_pkg::RXL_LSB +: 7];
    end
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  // ----------------------------------------------------------------
  // per-operation latching
  // ----------------------------------------------------------------
  assign is_standalone = (op_kind == 2'h0);
  assign is_rx         = (op_kind == 2'h2);
  assign next_key      = is_standalone ? standalone_key_choice
                       : (is_rx ? receive_key_choice : transmit_key_choice);
  // clear counts have no meaning for stand-alone work
  assign next_clear    = is_standalone ? 7'h00
                       : (is_rx ? rx_clear_count : tx_clear_count);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      active_mode      <= isc_pkg::MODE_RST;
      active_tag_code  <= isc_pkg::TAG_RST;
      active_tag_bytes <= isc_pkg::TAG_BYTES_RST;
      active_key       <= 1'b0;
      active_clear     <= isc_pkg::CLEAR_RST;
      tag_code_err     <= 1'b0;
      lat_head         <= isc_pkg::HEAD_RST;
      lat_rx           <= 1'b0;
      lat_txl          <= isc_pkg::CLEAR_RST;
      lat_rxl          <= isc_pkg::CLEAR_RST;
    end
    else if (op_start)
    begin
      // settings are sampled here only, so writes mid-packet wait
      active_mode      <= is_standalone ? isc_pkg::ISC_OFF
                                        : inline_protect_mode;
      active_tag_code  <= tag_length_code;
      active_tag_bytes <= {1'b0, tag_length_code, 1'b0} + 5'h02;
      active_key       <= next_key;
      active_clear     <= next_clear;
      tag_code_err     <= (tag_length_code == isc_pkg::TAG_RESERVED);
      lat_head         <= mac_head_select;
      lat_rx           <= is_rx;
      lat_txl          <= tx_clear_count;
      lat_rxl          <= rx_clear_count;
    end
  end

  // ----------------------------------------------------------------
  // CBC-MAC head byte
  // ----------------------------------------------------------------
  isc_head_byte u_head (
    .mode       (active_mode),
    .head_sel   (lat_head),
    .is_rx      (lat_rx),
    .pkt_len    (pkt_len),
    .tx_clear   (lat_txl),
    .rx_clear   (lat_rxl),
    .first_data (first_data),
    .head_byte  (head_byte),
    .len_first  (len_first)
  );

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mac_head_byte <= 8'h00;
      mac_len_first <= 1'b0;
    end
    else
    begin
      mac_head_byte <= head_byte;
      mac_len_first <= len_first;
    end
  end

endmodule : isc_control

/* src/isc_head_byte.sv */
/*
  Combinational selector of the first CBC-MAC input byte.
  Assumes the caller registers the result and supplies latched settings.
*/
`timescale 1ns/10ps
module isc_head_byte (
  input  wire logic [1:0] mode,         // latched security mode
  input  wire logic       head_sel,     // latched head select
  input  wire logic       is_rx,        // operation is a receive
  input  wire logic [7:0] pkt_len,      // packet length field
  input  wire logic [6:0] tx_clear,     // latched transmit clear count
  input  wire logic [6:0] rx_clear,     // latched receive clear count
  input  wire logic [7:0] first_data,   // first payload byte
  output wire logic [7:0] head_byte,    // first byte into CBC-MAC
  output wire logic       len_first     // length byte is prepended
);

  wire logic [7:0] tx_auth_len;
  wire logic [7:0] rx_auth_len;
  wire logic       plain_mac;

  // only plain CBC-MAC honours the head select, never CCM
  assign plain_mac   = (mode == isc_pkg::ISC_MAC);
  assign len_first   = plain_mac & head_sel;
  assign tx_auth_len = pkt_len - {1'b0, tx_clear} - isc_pkg::LEN_OVERHEAD;
  assign rx_auth_len = {1'b0, rx_clear};
  assign head_byte   = !len_first ? first_data
                     : (is_rx ? rx_auth_len : tx_auth_len);

endmodule : isc_head_byte

/* testbench/isc_control_sva.sv */
/*
  Checker for the in-line security control block, bound to isc_control.
  Assumes it sees the block's ports only, on ref_clk with rstn low active.
*/
`timescale 1ns/10ps
module isc_control_sva (
  input logic        ref_clk,            // system clock
  input logic        rstn,               // async reset, active low
  input logic [5:0]  reg_addr,           // register address
  input logic        reg_wr,             // write strobe
  input logic [15:0] reg_wdata,          // write data
  input logic        reg_rd,             // read strobe
  input logic [15:0] reg_rdata,          // read data
  input logic        op_start,           // operation start
  input logic [1:0]  op_kind,            // operation kind
  input logic [7:0]  first_data,         // first payload byte
  input logic        rx_buffer_guard_en, // receive buffer guard
  input logic [1:0]  active_mode,        // latched mode
  input logic [2:0]  active_tag_code,    // latched tag code
  input logic [4:0]  active_tag_bytes,   // tag bytes
  input logic        active_key,         // latched key
  input logic [6:0]  active_clear,       // latched clear count
  input logic [7:0]  mac_head_byte,      // first mac byte
  input logic        mac_len_first,      // length byte first
  input logic        tag_code_err        // reserved tag flag
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  property p_guard;
    reg_wr && reg_addr == 6'h19 |=> rx_buffer_guard_en == $past(reg_wdata[9]);
  endproperty
  a_guard: assert property (p_guard) else $error("guard bit not updated");
  property p_alone;
    op_start && op_kind == 2'h0 |=> active_mode == 2'h0 && active_clear == 7'h00;
  endproperty
  a_alone: assert property (p_alone) else $error("standalone op not plain");
  property p_bytes;
    active_tag_bytes == {1'b0, active_tag_code, 1'b0} + 5'h02;
  endproperty
  a_bytes: assert property (p_bytes) else $error("tag bytes wrong");
  property p_err;
    tag_code_err == (active_tag_code == 3'h0);
  endproperty
  a_err: assert property (p_err) else $error("tag error flag wrong");
  property p_hold_mode;
    !op_start |=> $stable(active_mode) && $stable(active_tag_code);
  endproperty
  a_hold_mode: assert property (p_hold_mode) else $error("mode moved mid op");
  property p_hold_key;
    !op_start |=> $stable(active_key) && $stable(active_clear);
  endproperty
  a_hold_key: assert property (p_hold_key) else $error("key moved mid op");
  property p_len;
    mac_len_first |-> $past(active_mode) == 2'h1;
  endproperty
  a_len: assert property (p_len) else $error("length first outside mac mode");
  property p_head;
    $past(rstn) && !mac_len_first |-> mac_head_byte == $past(first_data);
  endproperty
  a_head: assert property (p_head) else $error("head byte not first data");
  property p_rsvd;
    reg_rd && reg_addr == 6'h19 |=> reg_rdata[15:10] == 6'h00;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule : isc_control_sva

bind isc_control isc_control_sva u_isc_control_sva (.ref_clk(ref_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .op_start(op_start), .op_kind(op_kind), .first_data(first_data),
  .rx_buffer_guard_en(rx_buffer_guard_en), .active_mode(active_mode),
  .active_tag_code(active_tag_code), .active_tag_bytes(active_tag_bytes),
  .active_key(active_key), .active_clear(active_clear), .mac_head_byte(mac_head_byte),
  .mac_len_first(mac_len_first), .tag_code_err(tag_code_err));

/* testbench/tb_top.sv */
/*
  Testbench for isc_control: register access and operation latching.
  Assumes a one-cycle register strobe port and a one-cycle op_start pulse.
*/
`timescale 1ns/10ps
module tb_top;
  logic        ref_clk, rstn, reg_wr, reg_rd, op_start, guard, key, len_first, err;
  logic [5:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0]  op_kind, mode;
  logic [7:0]  pkt_len, first_data, head;
  logic [2:0]  tag_code;
  logic [4:0]  tag_bytes;
  logic [6:0]  clear;
  int          n_mismatch, comparisons;
  isc_control u_isc_control (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_start(op_start), .op_kind(op_kind), .pkt_len(pkt_len), .first_data(first_data),
    .rx_buffer_guard_en(guard), .active_mode(mode), .active_tag_code(tag_code),
    .active_tag_bytes(tag_bytes), .active_key(key), .active_clear(clear),
    .mac_head_byte(head), .mac_len_first(len_first), .tag_code_err(err));
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", exp, reg_rdata);
  endtask : rd
  task automatic op(input logic [1:0] k);
    @(posedge ref_clk);
    op_kind <= k;
    op_start <= 1'b1;
    @(posedge ref_clk);
    op_start <= 1'b0;
    #1;
  endtask : op
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_sim
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [2:0]  c;
    logic [2:0]  kv;
    logic [15:0] ctl;
    rstn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    op_start = 1'b0;
    reg_addr = 6'h00;
    reg_wdata = 16'h0000;
    op_kind = 2'h0;
    pkt_len = 8'h14;
    first_data = 8'hA5;
    repeat (20) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(6'h19, 16'h03C4);
    rd(6'h1A, 16'h0000);
    rd(6'h05, 16'h0000);
    chk("guard", 16'h0001, guard);
    wr(6'h1A, 16'h0503);
    rd(6'h1A, 16'h0503);
    for (int i = 0; i < 4; i++)
    begin
      c = 3'(2 * i + 1);
      kv = {i[1], ~i[0], i[0]};
      ctl = {6'h00, 2'h1, i[0], ~i[0], i[1], c, 2'(i)};
      wr(6'h19, ctl);
      rd(6'h19, ctl);
      chk("guard", 16'h0000, guard);
      for (int k = 0; k < 3; k++)
      begin
        op(2'(k));
        chk("mode", (k == 0) ? 16'h0 : 16'(i), mode);
        chk("key", kv[k], key);
        chk("clear", (k == 0) ? 16'h0 : (k == 1) ? 16'h5 : 16'h3, clear);
        chk("tag_bytes", 16'(2 * c + 2), tag_bytes);
        chk("tag_code", 16'(c), tag_code);
        chk("tag_err", (c == 3'h0), err);
        @(posedge ref_clk);
        #1;
        chk("len_first", (i == 1 && k != 0), len_first);
        chk("head", (i == 1 && k == 1) ? 16'h0D
                    : ((i == 1 && k == 2) ? 16'h03 : 16'hA5), head);
      end
    end
    wr(6'h19, 16'h00C5);
    op(2'h1);
    @(posedge ref_clk);
    #1;
    chk("head", 16'hA5, head);
    wr(6'h19, 16'h0007);
    chk("mode", 16'h1, mode);
    chk("key", 16'h1, key);
    op(2'h1);
    chk("mode", 16'h3, mode);
    chk("key", 16'h0, key);
    end_sim();
  end
endmodule : tb_top
